// ===== cerf_pkg.sv
package cerf_pkg;

	// Timing
	localparam int PCLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 24;
	localparam int TICK_DIV = (TICK_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam int NOMINAL_TICK_HZ = 41666667;
	localparam int FINE_BITS = 5;
	localparam int NUM_CH = 4;

	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GATE_WIDTH = 8'h04;
	localparam logic [7:0] OFS_DELAY = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_TICK_COUNT = 8'h10;
	localparam logic [7:0] OFS_PPS_COUNT = 8'h14;

	// Reset values
	localparam logic [2:0] RST_MAJORITY = 3'h1;
	localparam logic [11:0] RST_GATE_WIDTH = 12'h00A;
	localparam logic [5:0] RST_DELAY = 6'h06;

	// Edge byte layout
	localparam int BIT_TRIG_FLAG = 7;
	localparam int BIT_EDGE_PRESENT = 5;
	localparam logic [7:0] RISE_NONE = 8'h00;
	localparam logic [7:0] FALL_NONE = 8'h01;

	// Status nibble bits
	localparam int ST_PPS_PENDING = 0;
	localparam int ST_DATA_REMAIN = 1;
	localparam int ST_GPS_BAD = 2;
	localparam int ST_FREQ_FAIL = 3;

	typedef struct packed {
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] year;
		logic [7:0] fix_letter;
		logic [7:0] sats;
		logic signed [15:0] offset_ms;
	} cerf_gps_s;

	typedef struct packed {
		logic [31:0] tick_count;
		logic [7:0][7:0] edge_byte;
		logic [31:0] pps_count;
		cerf_gps_s gps;
		logic [3:0] status;
	} cerf_line_s;

	typedef enum logic [1:0] {
		CERF_IDLE = 2'b00,
		CERF_LOAD = 2'b01,
		CERF_SEND = 2'b10
	} cerf_state_e;

endpackage

// ===== cerf_formatter.sv
`timescale 1ns/1ps
`default_nettype none

module cerf_formatter
	import cerf_pkg::*;
#(
	parameter int DLY_DEPTH = 64,
	parameter int LINE_DEPTH = 32,
	parameter int FREQ_TOL = 1000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] disc_in,
	input wire logic [NUM_CH-1:0][FINE_BITS-1:0] fine_edge_timer,
	input wire logic pps_in,
	input wire cerf_gps_s gps_in,
	input wire logic gps_bad,
	output logic coincidence_gate_out,
	output logic line_valid,
	input wire logic line_ready,
	output cerf_line_s line_data
);

	localparam int DW = $clog2(DLY_DEPTH);
	localparam int LW = $clog2(LINE_DEPTH);
	localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
	localparam logic [31:0] FREQ_LO = 32'(NOMINAL_TICK_HZ - FREQ_TOL);
	localparam logic [31:0] FREQ_HI = 32'(NOMINAL_TICK_HZ + FREQ_TOL);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers and tick divider

	logic [NUM_CH-1:0] disc_s1_reg, disc_s2_reg, disc_prev_reg;
	logic pps_s1_reg, pps_s2_reg, pps_prev_reg;
	logic [1:0] div_reg;
	logic tick_en;
	logic [31:0] tick_cnt_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disc_s1_reg <= '0;
			disc_s2_reg <= '0;
			disc_prev_reg <= '0;
			pps_s1_reg <= 1'b0;
			pps_s2_reg <= 1'b0;
			pps_prev_reg <= 1'b0;
		end else begin
			disc_s1_reg <= disc_in;
			disc_s2_reg <= disc_s1_reg;
			disc_prev_reg <= disc_s2_reg;
			pps_s1_reg <= pps_in;
			pps_s2_reg <= pps_s1_reg;
			pps_prev_reg <= pps_s2_reg;
		end
	end

	assign tick_en = (div_reg == TICK_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= '0;
			tick_cnt_reg <= '0;
		end else begin
			div_reg <= tick_en ? 2'h0 : div_reg + 2'h1;
			if (tick_en)
				tick_cnt_reg <= tick_cnt_reg + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [2:0] majority_reg;
	logic [11:0] gate_width_reg;
	logic [5:0] delay_reg;
	logic [31:0] pps_count_reg;
	logic pps_pending_reg, freq_fail_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;
	logic [31:0] rd_mux;
	logic addr_ok, wr_go, rd_go;
	logic [LW:0] line_wr_reg, line_rd_reg;
	cerf_state_e state_reg;

	assign wr_go = psel & penable & pwrite & ~pready_reg;
	assign rd_go = psel & penable & ~pwrite & ~pready_reg;
	assign addr_ok = (paddr == OFS_CTRL) | (paddr == OFS_GATE_WIDTH) | (paddr == OFS_DELAY) |
		(paddr == OFS_STATUS) | (paddr == OFS_TICK_COUNT) | (paddr == OFS_PPS_COUNT);
	assign rd_mux = (paddr == OFS_CTRL) ? {29'h0, majority_reg} :
		(paddr == OFS_GATE_WIDTH) ? {20'h0, gate_width_reg} :
		(paddr == OFS_DELAY) ? {26'h0, delay_reg} :
		(paddr == OFS_STATUS) ? {14'h0, 2'(state_reg), (11 - LW)'(0), (LW + 1)'(line_wr_reg - line_rd_reg),
			coincidence_gate_out, freq_fail_reg, gps_bad, pps_pending_reg} :
		(paddr == OFS_TICK_COUNT) ? tick_cnt_reg :
		(paddr == OFS_PPS_COUNT) ? pps_count_reg : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			majority_reg <= RST_MAJORITY;
			gate_width_reg <= RST_GATE_WIDTH;
			delay_reg <= RST_DELAY;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= psel & penable & ~pready_reg;
			pslverr_reg <= psel & penable & ~pready_reg & ~addr_ok;
			if (rd_go)
				prdata_reg <= rd_mux;
			if (wr_go && paddr == OFS_CTRL)
				majority_reg <= pwdata[2:0];
			if (wr_go && paddr == OFS_GATE_WIDTH)
				gate_width_reg <= pwdata[11:0];
			if (wr_go && paddr == OFS_DELAY)
				delay_reg <= pwdata[5:0];
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	////////////////////////////////////////////////////////////////////////
	// Edge capture within one tick and channel gates

	logic [NUM_CH-1:0] rise_seen_reg, fall_seen_reg;
	logic [NUM_CH-1:0][FINE_BITS-1:0] rise_fine_reg, fall_fine_reg;
	logic [NUM_CH-1:0][11:0] gate_cnt_reg;
	logic [NUM_CH-1:0] gate_on;
	logic [2:0] gate_sum;
	logic maj_met;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic rise_now, fall_now;
			assign rise_now = disc_s2_reg[ch] & ~disc_prev_reg[ch];
			assign fall_now = ~disc_s2_reg[ch] & disc_prev_reg[ch];
			assign gate_on[ch] = (gate_cnt_reg[ch] != 12'h0);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rise_seen_reg[ch] <= 1'b0;
					fall_seen_reg[ch] <= 1'b0;
					rise_fine_reg[ch] <= '0;
					fall_fine_reg[ch] <= '0;
					gate_cnt_reg[ch] <= '0;
				end else begin
					if (rise_now) begin
						rise_seen_reg[ch] <= 1'b1;
						rise_fine_reg[ch] <= fine_edge_timer[ch];
					end else if (tick_en) begin
						rise_seen_reg[ch] <= 1'b0;
					end
					if (fall_now) begin
						fall_seen_reg[ch] <= 1'b1;
						fall_fine_reg[ch] <= fine_edge_timer[ch];
					end else if (tick_en) begin
						fall_seen_reg[ch] <= 1'b0;
					end
					if (tick_en && rise_seen_reg[ch])
						gate_cnt_reg[ch] <= gate_width_reg;
					else if (tick_en && gate_on[ch])
						gate_cnt_reg[ch] <= gate_cnt_reg[ch] - 12'h1;
				end
			end
		end
	endgenerate

	assign gate_sum = 3'(gate_on[0]) + 3'(gate_on[1]) + 3'(gate_on[2]) + 3'(gate_on[3]);
	assign maj_met = (majority_reg != 3'h0) && (gate_sum >= majority_reg);

	logic trig_reg, trig_prev_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
		end else begin
			trig_reg <= maj_met;
			trig_prev_reg <= trig_reg;
		end
	end
	assign coincidence_gate_out = trig_reg;

	////////////////////////////////////////////////////////////////////////
	// Delay line of per-tick edge records

	logic [47:0] dly_mem [DLY_DEPTH];
	logic [DW-1:0] dly_wp_reg, dly_rp;
	logic [47:0] dly_in, dly_out;

	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_pack
			assign dly_in[ch*12 +: 12] = {rise_seen_reg[ch], rise_fine_reg[ch],
				fall_seen_reg[ch], fall_fine_reg[ch]};
		end
	endgenerate

	assign dly_rp = dly_wp_reg - DW'(delay_reg);
	assign dly_out = dly_mem[dly_rp];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dly_wp_reg <= '0;
		else if (tick_en)
			dly_wp_reg <= dly_wp_reg + DW'(1);
	end

	always_ff @(posedge pclk) begin
		if (tick_en)
			dly_mem[dly_wp_reg] <= dly_in;
	end

	////////////////////////////////////////////////////////////////////////
	// Event line store

	logic [80:0] line_mem [LINE_DEPTH];
	logic first_pend_reg, any_edge, line_wr, line_full;
	logic [7:0][7:0] enc_bytes;
	logic [80:0] line_rdw;

	assign any_edge = |{dly_out[47], dly_out[41], dly_out[35], dly_out[29],
		dly_out[23], dly_out[17], dly_out[11], dly_out[5]};
	assign line_full = (line_wr_reg - line_rd_reg) == (LW + 1)'(LINE_DEPTH);
	assign line_wr = tick_en & trig_reg & any_edge & ~line_full & (state_reg == CERF_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			first_pend_reg <= 1'b1;
		else if (!trig_reg)
			first_pend_reg <= 1'b1;
		else if (line_wr)
			first_pend_reg <= 1'b0;
	end

	always_ff @(posedge pclk) begin
		if (line_wr)
			line_mem[line_wr_reg[LW-1:0]] <= {first_pend_reg, tick_cnt_reg, dly_out};
	end

	assign line_rdw = line_mem[line_rd_reg[LW-1:0]];

	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_enc
			logic [11:0] e;
			logic flag;
			assign e = line_rdw[ch*12 +: 12];
			assign flag = (ch == 0) ? line_rdw[80] : 1'b0;
			assign enc_bytes[7 - 2*ch] = e[11] ? {flag, 2'b01, e[10:6]} : (RISE_NONE | {flag, 7'h00});
			assign enc_bytes[6 - 2*ch] = e[5] ? {2'b00, 1'b1, e[4:0]} : FALL_NONE;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// PPS latch and frequency check

	logic pps_rise, line_take;
	logic [31:0] pps_diff;

	assign pps_rise = pps_s2_reg & ~pps_prev_reg;
	assign pps_diff = tick_cnt_reg - pps_count_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pps_count_reg <= '0;
			pps_pending_reg <= 1'b0;
			freq_fail_reg <= 1'b0;
		end else begin
			if (pps_rise) begin
				pps_count_reg <= tick_cnt_reg;
				freq_fail_reg <= (pps_diff < FREQ_LO) || (pps_diff > FREQ_HI);
			end
			if (pps_rise)
				pps_pending_reg <= 1'b1;
			else if (line_take)
				pps_pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Readout state machine

	cerf_line_s line_reg;
	logic valid_reg;
	logic [LW:0] rd_inc;

	assign rd_inc = line_rd_reg + (LW + 1)'(1);
	assign line_take = (state_reg == CERF_LOAD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= CERF_IDLE;
			valid_reg <= 1'b0;
			line_reg <= '0;
			line_wr_reg <= '0;
			line_rd_reg <= '0;
		end else begin
			if (line_wr)
				line_wr_reg <= line_wr_reg + (LW + 1)'(1);
			case (state_reg)
				CERF_IDLE: begin
					if (trig_prev_reg && !trig_reg && line_wr_reg != line_rd_reg)
						state_reg <= CERF_LOAD;
				end
				CERF_LOAD: begin
					line_reg.tick_count <= line_rdw[79:48];
					line_reg.edge_byte <= enc_bytes;
					line_reg.pps_count <= pps_count_reg;
					line_reg.gps <= gps_in;
					line_reg.status[ST_PPS_PENDING] <= pps_pending_reg | pps_rise;
					line_reg.status[ST_DATA_REMAIN] <= (rd_inc != line_wr_reg);
					line_reg.status[ST_GPS_BAD] <= gps_bad;
					line_reg.status[ST_FREQ_FAIL] <= freq_fail_reg;
					valid_reg <= 1'b1;
					state_reg <= CERF_SEND;
				end
				CERF_SEND: begin
					if (line_ready) begin
						valid_reg <= 1'b0;
						line_rd_reg <= rd_inc;
						state_reg <= (rd_inc == line_wr_reg) ? CERF_IDLE : CERF_LOAD;
					end
				end
				default: begin
					state_reg <= CERF_IDLE;
					valid_reg <= 1'b0;
				end
			endcase
		end
	end

	assign line_valid = valid_reg;
	assign line_data = line_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks

	chk_gate_load: assert property (@(posedge pclk) disable iff (!presetn)
		(tick_en && rise_seen_reg[0]) |=> (gate_cnt_reg[0] == $past(gate_width_reg)))
		else $error("channel gate not loaded with width");

	chk_trig_majority: assert property (@(posedge pclk) disable iff (!presetn)
		coincidence_gate_out == $past(maj_met))
		else $error("trigger not following majority");

	chk_trig_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(gate_sum == 3'h1 && majority_reg == 3'h2) |=> !coincidence_gate_out)
		else $error("trigger with single gate at two-fold");

	chk_tick_grid: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(tick_en) |-> $stable(gate_cnt_reg))
		else $error("gate changed off the tick grid");

	chk_single_width: assert property (@(posedge pclk) disable iff (!presetn)
		(tick_en && rise_seen_reg == 4'hF && gate_on == 4'h0 && majority_reg != 3'h0 && majority_reg <= 3'h4) |=>
		(gate_cnt_reg[0] == gate_width_reg) ##1 coincidence_gate_out)
		else $error("same-tick trigger not at full width");

	chk_accept_window: assert property (@(posedge pclk) disable iff (!presetn)
		line_wr |-> coincidence_gate_out)
		else $error("edge stored outside trigger");

	chk_readout_start: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == CERF_IDLE && $fell(trig_reg) && line_wr_reg != line_rd_reg) |=>
		##1 line_valid)
		else $error("readout did not start after trigger");

	chk_trig_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(line_valid && line_data.edge_byte[7][BIT_EDGE_PRESENT] == 1'b0) |->
		(line_data.edge_byte[7][6:0] == 7'h00))
		else $error("empty rising byte not zero");

	chk_flag_later: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == CERF_LOAD && $past(state_reg) == CERF_SEND) |=> !line_data.edge_byte[7][BIT_TRIG_FLAG])
		else $error("trigger flag on a later line");

	chk_empty_fall: assert property (@(posedge pclk) disable iff (!presetn)
		(line_valid && !line_data.edge_byte[6][BIT_EDGE_PRESENT]) |-> line_data.edge_byte[6] == FALL_NONE)
		else $error("empty falling byte not 01");

	chk_pps_latch: assert property (@(posedge pclk) disable iff (!presetn)
		pps_rise |=> (pps_count_reg == $past(tick_cnt_reg)) && pps_pending_reg)
		else $error("pps count not latched");

	chk_data_remain: assert property (@(posedge pclk) disable iff (!presetn)
		(line_valid && line_ready && !line_data.status[ST_DATA_REMAIN]) |=> state_reg == CERF_IDLE)
		else $error("data-remain bit wrong");

	chk_line_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(line_valid && !line_ready) |=> line_valid && $stable(line_data))
		else $error("line changed before accepted");

	cov_trigger: cover property (@(posedge pclk) disable iff (!presetn) $rose(coincidence_gate_out));
	cov_line_out: cover property (@(posedge pclk) disable iff (!presetn) line_valid && line_ready);
	cov_multi_line: cover property (@(posedge pclk) disable iff (!presetn)
		line_valid && line_data.status[ST_DATA_REMAIN]);
	cov_pps: cover property (@(posedge pclk) disable iff (!presetn) pps_rise);

endmodule // cerf_formatter

`default_nettype wire

// ===== cerf_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cerf_host_model
	import cerf_pkg::*;
#(
	parameter int STALL = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic line_valid,
	input wire cerf_line_s line_data,
	output logic line_ready
);
	cerf_line_s lines [0:7];
	logic [3:0] n_lines;
	logic [3:0] wait_cnt;
	logic [31:0] ticks_since_pps;

	////////////////////////////////////////////////////////////////
	// event time base
	// Slow reader: stalls before taking each line
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_lines <= 4'h0;
			wait_cnt <= 4'h0;
			line_ready <= 1'b0;
			ticks_since_pps <= 32'h0;
		end else if (line_valid && line_ready) begin
			lines[n_lines[2:0]] <= line_data;
			n_lines <= n_lines + 4'h1;
			ticks_since_pps <= line_data.tick_count - line_data.pps_count;
			line_ready <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (line_valid && wait_cnt == STALL[3:0]) begin
			line_ready <= 1'b1;
		end else if (line_valid) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // cerf_host_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import cerf_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic er;
	logic [NUM_CH-1:0] disc_in;
	logic [NUM_CH-1:0][FINE_BITS-1:0] fine;
	logic pps_in, gps_bad, trig, line_valid, line_ready;
	cerf_gps_s gps;
	cerf_line_s line_data;
	int fails, n_tests, trig_hi;

	cerf_formatter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .disc_in(disc_in), .fine_edge_timer(fine), .pps_in(pps_in),
		.gps_in(gps), .gps_bad(gps_bad), .coincidence_gate_out(trig),
		.line_valid(line_valid), .line_ready(line_ready), .line_data(line_data));

	cerf_host_model host (.pclk(pclk), .presetn(presetn), .line_valid(line_valid),
		.line_data(line_data), .line_ready(line_ready));

	////////////////////////////////////////////////////////////////
	// Clock and trigger length counter
	always #4 pclk = ~pclk;
	always @(negedge pclk) begin
		trig_hi <= trig_hi + ((trig === 1'b1) ? 1 : 0);
	end

	////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic give_verdict();
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) fails++;
	endtask

	task automatic drive(input logic [3:0] v, input int cyc);
		disc_in <= v;
		repeat (cyc) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		apb(0, OFS_CTRL, 32'h0);
		chk("majority", 64'(RST_MAJORITY), rd);
		chk("mapped err", 64'h0, er);
		apb(0, OFS_GATE_WIDTH, 32'h0);
		chk("gate width", 64'h00A, rd);
		apb(0, OFS_DELAY, 32'h0);
		chk("delay", 64'h006, rd);
		apb(0, 8'h18, 32'h0);
		chk("unmapped err", 64'h1, er);
		chk("unmapped data", 64'h0, rd);
		apb(1, OFS_GATE_WIDTH, 32'h00000005);
		apb(0, OFS_GATE_WIDTH, 32'h0);
		chk("width write", 64'h005, rd);
		apb(1, OFS_GATE_WIDTH, 32'h0000000A);
		apb(1, OFS_PPS_COUNT, 32'hFFFFFFFF);
		apb(0, OFS_PPS_COUNT, 32'h0);
		chk("pps count ro", 64'h0, rd);
	endtask

	task automatic t_event();
		logic [31:0] ppsv;
		int k;
		pps_in <= 1'b1;
		repeat (6) @(posedge pclk);
		pps_in <= 1'b0;
		repeat (10) @(posedge pclk);
		apb(0, OFS_PPS_COUNT, 32'h0);
		ppsv = rd;
		apb(0, OFS_STATUS, 32'h0);
		chk("status reg", 64'h7, rd);
		gps_bad <= 1'b0;
		trig_hi = 0;
		drive(4'h4, 6);
		drive(4'h0, 60);
		chk("single trigger cycles", 64'd30, trig_hi);
		k = 0;
		while (host.n_lines !== 4'h2 && k < 400) begin
			@(posedge pclk);
			k++;
		end
		chk("line count", 64'h2, host.n_lines);
		chk("line1 edges", 64'h8001000138010001, host.lines[0].edge_byte);
		chk("line2 edges", 64'h0001000100380001, host.lines[1].edge_byte);
		chk("tick step", 64'h2, host.lines[1].tick_count - host.lines[0].tick_count);
		chk("pps count", 64'(ppsv), host.lines[0].pps_count);
		chk("gps fields", 64'(gps), 64'(host.lines[1].gps));
		chk("status1", 64'hB, 64'(host.lines[0].status));
		chk("status2", 64'h8, 64'(host.lines[1].status));
		chk("pps to event ticks", 64'(32'(host.lines[1].tick_count - ppsv)), 64'(host.ticks_since_pps));
	endtask

	task automatic t_majority();
		apb(1, OFS_GATE_WIDTH, 32'h00000003);
		for (int m = 1; m <= 4; m++) begin
			apb(1, OFS_CTRL, 32'(m));
			for (int f = m - 1; f <= m; f++) begin
				if (f > 0) begin
					trig_hi = 0;
					drive(4'hF >> (4 - f), 3);
					drive(4'h0, 40);
					chk("majority trigger cycles", (f == m) ? 64'd9 : 64'd0, trig_hi);
				end
			end
		end
		chk("no late lines", 64'h2, host.n_lines);
	endtask

	task automatic t_adjacent();
		apb(1, OFS_CTRL, 32'h00000002);
		trig_hi = 0;
		drive(4'h1, 3);
		drive(4'h0, 6);
		drive(4'h2, 3);
		drive(4'h0, 40);
		chk("adjacent gates", 64'd0, trig_hi);
		trig_hi = 0;
		drive(4'h1, 3);
		drive(4'h2, 3);
		drive(4'h0, 40);
		chk("overlap cycles", 64'd6, trig_hi);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		disc_in = 4'h0;
		fine = {5'h1C, 5'h18, 5'h05, 5'h04};
		pps_in = 1'b0;
		gps_bad = 1'b1;
		gps = '{month: 8'h08, day: 8'h08, year: 8'h03, fix_letter: 8'h41, sats: 8'h04, offset_ms: 16'hFE7B};
		fails = 0;
		n_tests = 0;
		trig_hi = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_event();
		t_majority();
		t_adjacent();
		give_verdict();
	end

	initial begin
		#60000;
		fails++;
		give_verdict();
	end
endmodule // tb_top

`default_nettype wire
